// ### cgw_pkg.sv
package cgw_pkg;
  // ----------------------------------------------------------------
  // guard control register
  // ----------------------------------------------------------------
  localparam logic [7:0] GUARD_KEY_WRITE = 8'h5a;
  localparam logic [7:0] GUARD_KEY_READ  = 8'h69;
  localparam logic [7:0] GUARD_CTRL_RST  = 8'h00;
  localparam int         GUARD_IS_POS    = 0;
  localparam int         GUARD_SEL_POS   = 2;
  localparam int         GUARD_CLR_POS   = 3;
  localparam int         GUARD_TMSEL_POS = 4;
  localparam int         GUARD_NMIES_POS = 6;
  localparam int         GUARD_NMI_POS   = 5;
  localparam int         GUARD_HOLD_POS  = 7;
  localparam int         GUARD_CNT_W     = 16;
  // ----------------------------------------------------------------
  // clock generation
  // ----------------------------------------------------------------
  localparam logic [4:0] MULT_RST        = 5'h1f;
  localparam logic [7:0] DCO_TAP_RST     = 8'h00;
  localparam int         CRYSTAL_HZ      = 32768;
  localparam int         CLK_HZ          = 200000000;
  localparam int         ACLK_HALF_CYC   = CLK_HZ / (2 * CRYSTAL_HZ);
  localparam int         OSC_STABLE_CYC  = 4096;
  localparam logic [1:0] XSEL_ACLK       = 2'h0;
  localparam logic [1:0] XSEL_ACLK2      = 2'h1;
  localparam logic [1:0] XSEL_ACLK4      = 2'h2;
  localparam logic [1:0] XSEL_MCLK       = 2'h3;

  typedef struct packed {
    logic clock_gen_off_hi;
    logic clock_gen_off_lo;
    logic osc_stop_bit;
    logic processor_halt_bit;
  } cgw_status_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } cgw_guard_bus_t;
endpackage

// ### cgw_clock_gen_and_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module cgw_clock_gen_and_watchdog (
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  input  wire cgw_pkg::cgw_status_t  i_status_word,
  input  wire cgw_pkg::cgw_guard_bus_t i_guard,
  input  wire logic [4:0]            i_mult,
  input  wire logic [1:0]            i_clock_buffer_output_sel,
  output logic [15:0]                o_guard_rdata,
  output logic                       o_aclk,
  output logic                       o_mclk,
  output logic                       o_clock_buffer_output,
  output logic                       o_power_up_clear,
  output logic                       o_interval_irq,
  output logic                       o_nmi_mode,
  output logic                       o_nmi_edge,
  output logic                       o_dco_on,
  output logic [7:0]                 o_dco_tap
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] aclk_div, next_aclk_div;
  logic [2:0]  aclk_cnt, next_aclk_cnt;
  logic [12:0] stable_cnt, next_stable_cnt;
  logic        osc_run, next_osc_run;
  logic [4:0]  mult, next_mult;
  logic [7:0]  tap, next_tap;
  logic [7:0]  mcnt, next_mcnt;
  logic [7:0]  edges, next_edges;
  logic        mclk, next_mclk;
  logic [7:0]  gctl, next_gctl;
  logic [15:0] gcnt, next_gcnt;
  logic        power_up_clear, next_puc;
  logic        irq, next_irq;
  logic        aclk_q, clock_buffer_output, next_clock_buffer_output;
  logic        deep;
  logic        aclk_tick;
  logic        expire;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    deep = i_status_word.osc_stop_bit & i_status_word.clock_gen_off_hi
         & i_status_word.clock_gen_off_lo & i_status_word.processor_halt_bit;
    next_osc_run = ~i_status_word.osc_stop_bit;
    aclk_tick = osc_run && (aclk_div == 16'(cgw_pkg::ACLK_HALF_CYC - 1));
    next_aclk_div = aclk_tick || !osc_run ? 16'h0000 : aclk_div + 16'h0001;
    next_aclk_cnt = aclk_tick ? aclk_cnt + 3'h1 : aclk_cnt;
    next_stable_cnt = stable_cnt;
    if (!osc_run) begin
      next_stable_cnt = 13'h0000;
    end else if (stable_cnt != 13'(cgw_pkg::OSC_STABLE_CYC)) begin
      next_stable_cnt = stable_cnt + 13'h0001;
    end
    next_mult = i_mult;
    // main clock: dco toggles every (tap+1) cycles
    next_mcnt = mcnt + 8'h01;
    next_mclk = mclk;
    next_edges = edges;
    if (mcnt >= tap) begin
      next_mcnt = 8'h00;
      next_mclk = ~mclk & ~i_status_word.clock_gen_off_lo;
      next_edges = edges + 8'h01;
    end
    // main clock halted at once, not at the next toggle
    if (i_status_word.clock_gen_off_lo) begin
      next_mcnt = 8'h00;
      next_mclk = 1'b0;
    end
    next_tap = tap;
    if (aclk_tick && aclk_cnt[0] && stable_cnt == 13'(cgw_pkg::OSC_STABLE_CYC)
        && !i_status_word.clock_gen_off_lo) begin
      next_edges = 8'h00;
      if (edges > {2'h0, mult, 1'b1} && tap != 8'hff) begin
        next_tap = tap + 8'h01;
      end else if (edges < {2'h0, mult, 1'b1} && tap != 8'h00) begin
        next_tap = tap - 8'h01;
      end
    end
    unique case (i_clock_buffer_output_sel)
      cgw_pkg::XSEL_ACLK:  next_clock_buffer_output = aclk_cnt[0];
      cgw_pkg::XSEL_ACLK2: next_clock_buffer_output = aclk_cnt[1];
      cgw_pkg::XSEL_ACLK4: next_clock_buffer_output = aclk_cnt[2];
      cgw_pkg::XSEL_MCLK:  next_clock_buffer_output = mclk;
    endcase
    next_gcnt = gctl[cgw_pkg::GUARD_HOLD_POS] ? gcnt : gcnt + 16'h0001;
    expire = gctl[cgw_pkg::GUARD_SEL_POS] ? (gcnt[12:0] == 13'h1fff) : (gcnt == 16'hffff);
    expire = expire & ~gctl[cgw_pkg::GUARD_HOLD_POS];
    next_gctl = gctl;
    next_puc = 1'b0;
    next_irq = 1'b0;
    if (expire) begin
      if (!gctl[cgw_pkg::GUARD_TMSEL_POS]) begin
        next_puc = 1'b1;
      end else begin
        next_irq = 1'b1;
      end
    end
    if (i_guard.wr) begin
      if (i_guard.wdata[15:8] == cgw_pkg::GUARD_KEY_WRITE) begin
        next_gctl = i_guard.wdata[7:0];
        next_gctl[cgw_pkg::GUARD_CLR_POS] = 1'b0;
        if (i_guard.wdata[cgw_pkg::GUARD_CLR_POS]) begin
          next_gcnt = 16'h0000;
        end
      end else begin
        next_puc = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers; puc is fed back as a synchronous clear
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aclk_div   <= 16'h0000;
      aclk_cnt   <= 3'h0;
      stable_cnt <= 13'h0000;
      osc_run    <= 1'b1;
      mult       <= cgw_pkg::MULT_RST;
      tap        <= cgw_pkg::DCO_TAP_RST;
      mcnt       <= 8'h00;
      edges      <= 8'h00;
      mclk       <= 1'b0;
      gctl       <= cgw_pkg::GUARD_CTRL_RST;
      gcnt       <= 16'h0000;
      power_up_clear        <= 1'b0;
      irq        <= 1'b0;
      clock_buffer_output       <= 1'b0;
      aclk_q     <= 1'b0;
      o_dco_on   <= 1'b1;
    end else if (power_up_clear) begin
      mult       <= cgw_pkg::MULT_RST;
      tap        <= 8'hff;
      gcnt       <= 16'h0000;
      gctl       <= cgw_pkg::GUARD_CTRL_RST;
      power_up_clear        <= 1'b0;
      irq        <= 1'b0;
      edges      <= 8'h00;
    end else begin
      aclk_div   <= next_aclk_div;
      aclk_cnt   <= next_aclk_cnt;
      stable_cnt <= next_stable_cnt;
      osc_run    <= next_osc_run;
      mult       <= next_mult;
      tap        <= next_tap;
      mcnt       <= next_mcnt;
      edges      <= next_edges;
      mclk       <= next_mclk;
      gctl       <= next_gctl;
      gcnt       <= next_gcnt;
      power_up_clear        <= next_puc;
      irq        <= next_irq;
      clock_buffer_output       <= next_clock_buffer_output;
      aclk_q     <= aclk_cnt[0];
      o_dco_on   <= ~deep & ~i_status_word.clock_gen_off_hi;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_guard_rdata <= 16'h0000;
    end else begin
      o_guard_rdata <= {cgw_pkg::GUARD_KEY_READ, gctl};
    end
  end

  assign o_aclk                = aclk_q;
  assign o_mclk                = mclk;
  assign o_clock_buffer_output = clock_buffer_output;
  assign o_power_up_clear      = power_up_clear;
  assign o_interval_irq        = irq;
  assign o_nmi_mode            = gctl[cgw_pkg::GUARD_NMI_POS];
  assign o_nmi_edge            = gctl[cgw_pkg::GUARD_NMIES_POS];
  assign o_dco_tap             = tap;
endmodule
`default_nettype wire

// ### cgw_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cgw_checker (
  input wire logic                    i_clk,
  input wire logic                    i_resetn,
  input wire cgw_pkg::cgw_status_t    i_status_word,
  input wire cgw_pkg::cgw_guard_bus_t i_guard,
  input wire logic [1:0]              i_clock_buffer_output_sel,
  input wire logic [15:0]             o_guard_rdata,
  input wire logic                    o_aclk,
  input wire logic                    o_mclk,
  input wire logic                    o_clock_buffer_output,
  input wire logic                    o_power_up_clear,
  input wire logic                    o_interval_irq,
  input wire logic                    o_nmi_mode,
  input wire logic                    o_nmi_edge,
  input wire logic                    o_dco_on,
  input wire logic [7:0]              o_dco_tap
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic ok;
  assign ok = i_guard.wr && i_guard.wdata[15:8] == 8'h5a;
  // ----------
  // properties
  // ----------
  bad_key_a: assert property (i_guard.wr && !ok |=> o_power_up_clear)
    else $error("no clear after bad key");
  read_back_a: assert property (ok ##1 !i_guard.wr && !o_power_up_clear |=>
    o_guard_rdata == {8'h69, $past(i_guard.wdata[7:0], 2) & 8'hf7}) else $error("bad readback");
  nmi_cfg_a: assert property (ok |=>
    {o_nmi_edge, o_nmi_mode} == $past(i_guard.wdata[6:5])) else $error("nmi bits wrong");
  puc_tap_a: assert property (o_power_up_clear |-> ##[0:1] o_dco_tap == 8'hff)
    else $error("tap not slowest");
  osc_stop_a: assert property (i_status_word.osc_stop_bit [*4] |-> $stable(o_aclk))
    else $error("aclk runs while stopped");
  deep_sleep_a: assert property ((&i_status_word) [*3] |-> !o_dco_on && $stable(o_mclk))
    else $error("clocks run in deep sleep");
  irq_mode_a: assert property (o_interval_irq |-> o_guard_rdata[4])
    else $error("irq outside timer mode");
  clock_buffer_output_aclk_a: assert property ((i_clock_buffer_output_sel == 2'h0) [*3] |->
    o_clock_buffer_output == o_aclk || o_clock_buffer_output == $past(o_aclk))
    else $error("pin not aclk");
  cover property (o_interval_irq);
  cover property (o_power_up_clear);
  cover property (ok);
endmodule
bind cgw_clock_gen_and_watchdog cgw_checker u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_status_word(i_status_word), .i_guard(i_guard), .i_clock_buffer_output_sel(i_clock_buffer_output_sel),
  .o_guard_rdata(o_guard_rdata), .o_aclk(o_aclk), .o_mclk(o_mclk),
  .o_clock_buffer_output(o_clock_buffer_output), .o_power_up_clear(o_power_up_clear),
  .o_interval_irq(o_interval_irq), .o_nmi_mode(o_nmi_mode), .o_nmi_edge(o_nmi_edge),
  .o_dco_on(o_dco_on), .o_dco_tap(o_dco_tap));
`default_nettype wire

// ### cgw_clock_buffer_output_sink.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// external user of the buffered clock
// ------------------------------------
module cgw_clock_buffer_output_sink (
  input  wire logic   i_clk,
  input  wire logic   i_resetn,
  input  wire logic   i_pin,
  output logic [31:0] o_period,
  output logic        o_edge
);
  logic [31:0] cnt;
  logic        last;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= '0;
      last <= 1'b0;
      o_period <= '0;
      o_edge <= 1'b0;
    end else begin
      last <= i_pin;
      o_edge <= i_pin && !last;
      cnt <= (i_pin && !last) ? 32'h1 : cnt + 32'h1;
      if (i_pin && !last) begin
        o_period <= cnt;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                    i_clk = 1'b0;
  logic                    i_resetn = 1'b0;
  cgw_pkg::cgw_status_t    st = '0;
  cgw_pkg::cgw_guard_bus_t gb = '0;
  logic [4:0]              mult = 5'h1f;
  logic [1:0]              sel = 2'h0;
  logic [15:0]             rdata;
  logic [7:0]              tap;
  logic [31:0]             period;
  logic                    aclk, mclk, cbo, power_up_clear, irq, nmi_m, nmi_e, dco_on, edg;
  int                      failures = 0;
  int                      checks = 0;
  int                      ctl, n, k;
  always #2.5 i_clk = ~i_clk;
  cgw_clock_gen_and_watchdog dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_status_word(st),
    .i_guard(gb), .i_mult(mult), .i_clock_buffer_output_sel(sel), .o_guard_rdata(rdata), .o_aclk(aclk),
    .o_mclk(mclk), .o_clock_buffer_output(cbo), .o_power_up_clear(power_up_clear),
    .o_interval_irq(irq), .o_nmi_mode(nmi_m), .o_nmi_edge(nmi_e), .o_dco_on(dco_on),
    .o_dco_tap(tap));
  cgw_clock_buffer_output_sink sink (.i_clk(i_clk), .i_resetn(i_resetn), .i_pin(cbo), .o_period(period),
    .o_edge(edg));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] d);
    tick(1);
    gb.wr = 1'b1;
    gb.wdata = d;
    tick(1);
    gb.wr = 1'b0;
  endtask
  // model: clear bit never reads back, key byte reads as 69h
  task automatic good(input logic [7:0] b);
    wr({8'h5a, b});
    ctl = b & 8'hf7;
    check({nmi_e, nmi_m}, ctl[6:5]);
    tick(1);
    check(rdata, {8'h69, ctl[7:0]});
  endtask
  // count cycles until irq (0), clear (1) or a pin edge (2)
  task automatic await(input int w, output int c);
    c = 0;
    do begin
      tick(1);
      c++;
    end while ((w == 0 ? irq : w == 1 ? power_up_clear : edg) !== 1'b1 && c < 70000);
  endtask
  initial begin
    repeat (98000) @(posedge i_clk);
    failures++;
    final_report();
  end
  initial begin
    void'($urandom(32'h809fd496));
    tick(5);
    i_resetn = 1'b1;
    good(8'h80);
    for (k = 0; k < 8; k++) begin
      mult = 5'($urandom);
      good({1'b1, 7'($urandom)});
    end
    for (k = 0; k < 4; k++) begin
      n = {$urandom} % 255;
      wr({(n[7:0] == 8'h5a) ? 8'hff : n[7:0], 8'h80});
      check(power_up_clear, 1'b1);
      good(8'h80);
    end
    // edges of aclk and aclk/4; a stuck divider shows as a wrong period
    for (k = 0; k < 3; k += 2) begin
      sel = 2'(k);
      await(2, n);
      await(2, n);
      check(period, (2 * cgw_pkg::ACLK_HALF_CYC) << k);
    end
    sel = 2'h2;
    tick(200);
    sel = 2'h3;
    tick(200);
    sel = 2'h0;
    st.osc_stop_bit = 1'b1;
    tick(50);
    st = 4'hf;
    tick(10);
    check(dco_on, 1'b0);
    st = '0;
    good(8'h1c);
    await(0, n);
    await(0, n);
    check(n, 8192);
    good(8'h0c);
    await(1, n);
    check(n > 8185 && n <= 8192, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
